// >>> adc_seq_pkg.sv
package adc_seq_pkg;
   // Field widths and special codes of the converter control fields
   localparam int CHGRP_W = 2;
   localparam int TRIG_W = 3;
   localparam int STIME_W = 5;
   localparam int PERINT_W = 4;
   localparam logic [CHGRP_W-1:0] CHGRP_SINGLE = 2'h0;
   localparam logic [TRIG_W-1:0] TRIG_AUTO = 3'h7;
   localparam logic [TRIG_W-1:0] TRIG_EXT_PIN = 3'h1;
   localparam logic [TRIG_W-1:0] TRIG_MANUAL = 3'h0;
   localparam logic [STIME_W-1:0] STIME_ZERO = 5'h00;
   localparam logic [PERINT_W-1:0] PERINT_EVERY = 4'h0;
   localparam int CONV_CYCLES = 12;

   typedef struct packed {
      logic [CHGRP_W-1:0] channel_group_select;
      logic simultaneous_sample_select;
      logic [TRIG_W-1:0] conversion_trigger_source;
      logic [STIME_W-1:0] auto_sample_time_count;
      logic [PERINT_W-1:0] conversions_per_interrupt;
   } adc_cfg_s;

   typedef enum logic [1:0] {ST_IDLE, ST_SAMPLE, ST_CONVERT} adc_state_e;
endpackage

// >>> adc_sequence_trigger_control.sv
`timescale 1ns/10ps
// How it works
// - Nonzero channel group with simultaneous bit clear samples channels one after another.
// - Trigger source 111 picks auto-convert, 001 the external pin, 000 manual convert; other codes start nothing.
// - Sequential, non-auto trigger, zero sample time flags possible misbehaviour.
// - External pin triggers convert during sleep and the interrupt wakes the device.
// - Asleep with nonzero per-interrupt count, pin triggers are ignored, device sleeps.
// - Interrupt follows count+1 conversions; zero means every conversion, waking from sleep.
module adc_sequence_trigger_control (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire adc_seq_pkg::adc_cfg_s cfg,
   input wire logic sleep_mode,
   input wire logic external_interrupt_zero_pin,
   input wire logic manual_convert,
   input wire logic conv_done,
   output logic [adc_seq_pkg::CHGRP_W-1:0] sample_channel,
   output logic sample_active,
   output logic convert_start,
   output logic adc_interrupt,
   output logic wake_request,
   output logic sequence_fault
);
   import adc_seq_pkg::*;

   // ==========================================================
   // Pin synchroniser and edge detect
   // ==========================================================
   // The pin is asynchronous: two flops before any logic looks at it
   logic pin_meta;
   logic pin_sync;
   logic pin_prev;

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         pin_meta <= 1'b0;
         pin_sync <= 1'b0;
      end else begin
         pin_meta <= external_interrupt_zero_pin;
         pin_sync <= pin_meta;
      end
   end

   // Resets low like the idle pin, so no false edge follows reset
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         pin_prev <= 1'b0;
      end else begin
         pin_prev <= pin_sync;
      end
   end

   wire pin_rise = pin_sync & ~pin_prev;

   // ==========================================================
   // Configuration decode
   // ==========================================================
   // Simultaneous sampling takes every channel at once, so it never steps
   wire multi_channel = (cfg.channel_group_select != CHGRP_SINGLE);
   wire sequential = multi_channel && !cfg.simultaneous_sample_select;
   wire auto_trig = (cfg.conversion_trigger_source == TRIG_AUTO);
   wire ext_trig = (cfg.conversion_trigger_source == TRIG_EXT_PIN);
   wire man_trig = (cfg.conversion_trigger_source == TRIG_MANUAL);
   wire stime_zero = (cfg.auto_sample_time_count == STIME_ZERO);
   wire per_every = (cfg.conversions_per_interrupt == PERINT_EVERY);
   // Flag only: the sequencer keeps running, so software sees the hazard rather than a hang
   wire bad_combo = sequential && !auto_trig && stime_zero;

   // ==========================================================
   // Trigger selection
   // ==========================================================
   // Silicon fault kept on purpose: a sleeping part with a count drops pin triggers
   wire pin_blocked = sleep_mode && !per_every;
   wire ext_go = ext_trig && pin_rise && !pin_blocked;
   wire man_go = man_trig && manual_convert;
   // Auto-convert restarts by itself whenever the sequencer is idle
   wire idle_go = auto_trig || ext_go || man_go;

   // ==========================================================
   // Sequencer state
   // ==========================================================
   adc_state_e state;
   adc_state_e next_state;
   logic [STIME_W-1:0] samp_cnt;
   logic [STIME_W-1:0] next_samp_cnt;
   logic [CHGRP_W-1:0] next_channel;
   logic next_start;

   // ==========================================================
   // Channel stepping
   // ==========================================================
   // Only one channel per pass unless sequential
   wire [CHGRP_W-1:0] last_ch = sequential ? cfg.channel_group_select : CHGRP_SINGLE;
   wire more_channels = (sample_channel != last_ch);
   wire [CHGRP_W-1:0] channel_inc = sample_channel + 2'h1;
   wire samp_done = (samp_cnt == STIME_ZERO);
   wire [STIME_W-1:0] samp_dec = samp_cnt - 5'h01;

   // ==========================================================
   // Sequencer next state
   // ==========================================================
   always_comb begin
      next_state = state;
      next_samp_cnt = samp_cnt;
      next_channel = sample_channel;
      next_start = 1'b0;
      case (state)
         ST_IDLE: begin
            if (idle_go) begin
               next_state = ST_SAMPLE;
               next_samp_cnt = cfg.auto_sample_time_count;
               next_channel = CHGRP_SINGLE;
            end
         end
         ST_SAMPLE: begin
            // A zero sample time still gives one sampling cycle
            if (samp_done) begin
               next_state = ST_CONVERT;
               next_start = 1'b1;
            end else begin
               next_samp_cnt = samp_dec;
            end
         end
         ST_CONVERT: begin
            if (conv_done) begin
               if (more_channels) begin
                  next_state = ST_SAMPLE;
                  next_channel = channel_inc;
                  next_samp_cnt = cfg.auto_sample_time_count;
               end else begin
                  next_state = ST_IDLE;
               end
            end
         end
         default: begin
            next_state = ST_IDLE;
         end
      endcase
   end

   // ==========================================================
   // Sequencer registers
   // ==========================================================
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= ST_IDLE;
         samp_cnt <= STIME_ZERO;
         sample_channel <= CHGRP_SINGLE;
      end else begin
         state <= next_state;
         samp_cnt <= next_samp_cnt;
         sample_channel <= next_channel;
      end
   end

   // ==========================================================
   // Sampling and conversion strobes
   // ==========================================================
   // convert_start lands on the same edge at which sampling ends
   wire next_sampling = (next_state == ST_SAMPLE);

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         sample_active <= 1'b0;
         convert_start <= 1'b0;
      end else begin
         sample_active <= next_sampling;
         convert_start <= next_start;
      end
   end

   // ==========================================================
   // Conversions-per-interrupt counter
   // ==========================================================
   logic [PERINT_W-1:0] conv_cnt;

   wire conv_end = (state == ST_CONVERT) && conv_done;
   // At-or-above, so lowering the count mid-block cannot strand the counter past it
   wire count_hit = (conv_cnt >= cfg.conversions_per_interrupt);
   wire [PERINT_W-1:0] conv_cnt_inc = conv_cnt + 4'h1;
   wire [PERINT_W-1:0] next_conv_cnt = count_hit ? PERINT_EVERY : conv_cnt_inc;
   wire irq_now = conv_end && count_hit;

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         conv_cnt <= PERINT_EVERY;
      end else begin
         if (conv_end) begin
            conv_cnt <= next_conv_cnt;
         end
      end
   end

   // ==========================================================
   // Interrupt and wake
   // ==========================================================
   // Wake only comes with an interrupt, on the same edge, so a blocked pin trigger never wakes the part
   wire wake_now = irq_now && sleep_mode;

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         adc_interrupt <= 1'b0;
         wake_request <= 1'b0;
      end else begin
         adc_interrupt <= irq_now;
         wake_request <= wake_now;
      end
   end

   // ==========================================================
   // Sequential sampling hazard flag
   // ==========================================================
   // Registered so the flag is a clean level one cycle after the fields change
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         sequence_fault <= 1'b0;
      end else begin
         sequence_fault <= bad_combo;
      end
   end
endmodule // adc_sequence_trigger_control

// >>> adc_seq_monitor.sv
`timescale 1ns/10ps
module adc_seq_monitor (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire adc_seq_pkg::adc_cfg_s cfg,
   input wire logic sleep_mode,
   input wire logic conv_done,
   input wire logic [adc_seq_pkg::CHGRP_W-1:0] sample_channel,
   input wire logic sample_active,
   input wire logic convert_start,
   input wire logic adc_interrupt,
   input wire logic wake_request,
   input wire logic sequence_fault
);
   import adc_seq_pkg::*;
   logic [5:0] run;
   wire fault_cond = cfg.channel_group_select != CHGRP_SINGLE && !cfg.simultaneous_sample_select
      && cfg.conversion_trigger_source != TRIG_AUTO && cfg.auto_sample_time_count == STIME_ZERO;
   wire refuse = sleep_mode && cfg.conversions_per_interrupt != PERINT_EVERY
      && cfg.conversion_trigger_source == TRIG_EXT_PIN;
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         run <= 6'h00;
      end else begin
         run <= sample_active ? run + 6'h01 : 6'h00;
      end
   end
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   sequence sample_end;
      sample_active ##1 !sample_active;
   endsequence
   a_sample_span: assert property (convert_start |-> run == {1'b0, cfg.auto_sample_time_count} + 6'h01)
      else $error("sample span wrong");
   a_start_order: assert property (sample_end |-> convert_start)
      else $error("no start after sample");
   a_fault_flag: assert property (1'b1 |=> sequence_fault == $past(fault_cond))
      else $error("fault flag wrong");
   a_pin_refused: assert property (refuse [*2] |-> !$rose(sample_active) && !wake_request)
      else $error("pin trigger not refused");
   a_int_cause: assert property (adc_interrupt |-> $past(conv_done))
      else $error("interrupt without done");
   a_int_every: assert property (conv_done && cfg.conversions_per_interrupt == PERINT_EVERY |=> adc_interrupt)
      else $error("interrupt missed");
   a_chan_step: assert property ($changed(sample_channel) && sample_channel != 2'h0 |->
      sample_channel == $past(sample_channel) + 2'h1) else $error("channel skipped");
   a_wake_cause: assert property (wake_request |-> adc_interrupt)
      else $error("wake without interrupt");
endmodule // adc_seq_monitor
bind adc_sequence_trigger_control adc_seq_monitor mon (.*);

// >>> adc_core_model.sv
`timescale 1ns/10ps
module adc_core_model (
   input wire logic core_clk,
   input wire logic convert_start,
   input wire logic slow,
   output logic conv_done = 1'b0
);
   int cnt = 0;
   // Slow mode stretches the conversion so later channels wait on the core
   always @(posedge core_clk) begin
      conv_done <= cnt == 1;
      cnt <= convert_start ? (slow ? 9 : 3) : (cnt > 0 ? cnt - 1 : 0);
   end
endmodule // adc_core_model

// >>> adc_sequence_trigger_control_bench.sv
`timescale 1ns/10ps
module adc_sequence_trigger_control_bench;
   import adc_seq_pkg::*;
   logic core_clk = 0, rst_n = 0, sleep_mode = 0, pin = 0, manual = 0, slow = 1;
   adc_cfg_s cfg = '0;
   logic conv_done, sample_active, convert_start, adc_interrupt, wake_request, sequence_fault;
   logic [CHGRP_W-1:0] sample_channel;
   int n_fail = 0, num_checks = 0, n_start = 0, n_wake = 0, n_int = 0, run = 0, len = 0, top = 0, cyc = 0;
   adc_sequence_trigger_control uut (.core_clk, .rst_n, .cfg, .sleep_mode, .external_interrupt_zero_pin(pin),
      .manual_convert(manual), .conv_done, .sample_channel, .sample_active, .convert_start, .adc_interrupt,
      .wake_request, .sequence_fault);
   adc_core_model core (.core_clk, .convert_start, .slow, .conv_done);
   initial forever #20 core_clk = ~core_clk;
   always @(posedge core_clk) begin
      cyc++;
      if (sample_active === 1'b1) run++;
      if (convert_start === 1'b1) begin
         len = run;
         run = 0;
         n_start++;
         if (sample_channel > top) top = sample_channel;
      end
      n_wake += (wake_request === 1'b1);
      n_int += (adc_interrupt === 1'b1);
      if (cyc > 3000) begin
         n_fail++;
         summarize();
      end
   end
   task chk(input string n, input int e, input logic [7:0] g);
      num_checks++;
      if (g !== 8'(e)) begin
         n_fail++;
         $display("[FAIL] %s exp %0d got %0d", n, e, g);
      end
   endtask
   task wt(input int n);
      repeat (n) @(posedge core_clk);
      #2;
   endtask
   task go(input adc_cfg_s c, input int n);
      cfg = c;
      n_start = 0;
      n_wake = 0;
      n_int = 0;
      wt(n);
   endtask
   task hit(input bit use_pin);
      if (use_pin) pin = 1;
      else manual = 1;
      wt(2);
      pin = 0;
      manual = 0;
      wt(30);
   endtask
   task summarize;
      $display("checks %0d fails %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   initial begin
      wt(4);
      rst_n = 1;
      go('{2'h3, 1'b0, TRIG_AUTO, 5'h02, 4'h3}, 150);
      chk("span", 3, 8'(len));
      chk("top", 3, 8'(top));
      chk("auto", 1, 8'(n_start > 4 && n_int > 0));
      go('{2'h3, 1'b0, 3'h2, 5'h02, 4'h3}, 60);
      go(cfg, 40);
      chk("idle", 0, 8'(n_start));
      $display("end auto");
      slow = 0;
      go('{2'h1, 1'b0, TRIG_MANUAL, STIME_ZERO, PERINT_EVERY}, 3);
      chk("fault", 1, 8'(sequence_fault));
      go('{2'h1, 1'b0, TRIG_MANUAL, 5'h04, PERINT_EVERY}, 3);
      chk("clear", 0, 8'(sequence_fault));
      hit(1'b0);
      chk("span", 5, 8'(len));
      chk("irq", 2, 8'(n_int));
      go('{2'h3, 1'b1, TRIG_MANUAL, STIME_ZERO, PERINT_EVERY}, 3);
      chk("simul", 0, 8'(sequence_fault));
      hit(1'b0);
      chk("single", 1, 8'(n_start));
      chk("short", 1, 8'(len));
      chk("irq1", 1, 8'(n_int));
      $display("end manual");
      sleep_mode = 1;
      go('{2'h0, 1'b0, TRIG_EXT_PIN, 5'h01, PERINT_EVERY}, 2);
      hit(1'b1);
      chk("wake", 1, 8'(n_wake));
      go('{2'h0, 1'b0, TRIG_EXT_PIN, 5'h01, 4'h2}, 2);
      hit(1'b1);
      chk("asleep", 0, 8'(n_start + n_wake));
      $display("end sleep");
      summarize();
   end
endmodule // adc_sequence_trigger_control_bench
